// File: src/two_wire_pkg.sv
// Constants, carriers and states shared by the two-wire serial port design
package two_wire_pkg;

    // ****************************************
    // Register offsets on the SFR port
    // ****************************************
    localparam logic [7:0] DATA_OFFSET = 8'h9a;
    localparam logic [7:0] OWN_ADDR_OFFSET = 8'h9b;
    localparam logic [7:0] CTRL_OFFSET = 8'he8;

    // ****************************************
    // Reset values and field layouts
    // ****************************************
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] OWN_ADDR_RESET = 8'h55;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Control bits software may write: 7, 6, 5, 3, 2
    localparam logic [7:0] CTRL_WR_MASK = 8'hec;
    // Position of the interface select bit in the sync port control register
    localparam int PORT_SELECT_BIT = 5;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int BYTE_W = 8;
    localparam int TX_FIFO_DEPTH = 16;

    // Control register, bit 7 first
    typedef struct packed {
        logic sw_data_out;
        logic sw_data_drive_enable;
        logic sw_clock_out;
        logic sw_data_in;
        logic role_select;
        logic slave_reset;
        logic slave_direction;
        logic byte_done_flag;
    } ctrl_t;

    // Drive request for one open-drain pin
    typedef struct packed {
        logic o;
        logic oe;
    } pin_drive_t;

    // Slave byte engine states, Gray codes along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_RX_BYTE = 3'h2,
        ST_RX_ACK = 3'h6,
        ST_TX_BYTE = 3'h7,
        ST_TX_ACK = 3'h5
    } slave_state_t;

endpackage : two_wire_pkg

// File: src/byte_fifo.sv
// Small FIFO with registered read data for the transmit path
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Filling side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Draining side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q, rd_ptr_q, rd_ptr_d;
    logic [CW-1:0] count_q, count_d;
    logic push, pop;

    // Handshakes and next pointers
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;
    assign rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    // Storage array
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= i_in_data;
        end
    end

    // Pointers, fill level and flags
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            o_out_valid <= 1'b0;
            o_in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
            o_out_valid <= (count_d != '0);
            o_in_ready <= (count_d != CW'(DEPTH));
        end
    end

    // Head word, bypassing a word written into an emptying FIFO
    always_ff @(posedge i_clk) begin
        if (push && (wr_ptr_q == rd_ptr_d)) begin
            o_out_data <= i_in_data;
        end else begin
            o_out_data <= mem_q[rd_ptr_d];
        end
    end

endmodule : byte_fifo

`default_nettype wire

// File: src/two_wire_serial_port.sv
// Two-wire serial port: software master, hardware slave and SFR file
//
// How it works
// - Two-wire port shares its two pins with SPI; only one owns them.
// - SPI select bit 5 set gives pins to SPI, clear to two-wire.
// - Two roles: software-driven master and hardware byte slave.
// - Master drives control bit 7 on data pin only while drive enable set.
// - Master control bit 6 makes data pin output when set, input when clear.
// - Master control bit 5 appears directly on the clock pin.
// - Master with drive enable clear latches data pin into bit 4 on clock.
// - Control bit 3 set selects software master, clear selects hardware slave.
// - Slave engine held in reset while control bit 2 is set.
// - Slave sets bit 1 while transmitting, clears it while receiving.
// - Slave sets bit 0 after each data byte transmitted or received, not after the address byte.
// - A data register access clears the done flag and interrupt request unless a byte completes in the same cycle.
// - Data writes supply bytes to send; reads return last received byte.
// - Own address register holds 7-bit address, resets to 55H, writable.
`timescale 1ns/1ps
`default_nettype none

module two_wire_serial_port
    import two_wire_pkg::*;
#(
    parameter int FIFO_DEPTH = TX_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // SFR access port
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    // Sync port control register value from the SPI block
    input wire logic [7:0] i_sync_port_control,
    // SPI drive requests for the shared pins
    input wire logic i_spi_data_o,
    input wire logic i_spi_data_oe,
    input wire logic i_spi_clock_o,
    input wire logic i_spi_clock_oe,
    // Shared serial data pin
    input wire logic i_serial_data_pin,
    output logic o_serial_data_pin,
    output logic o_serial_data_pin_oe,
    // Shared serial clock pin
    input wire logic i_serial_clock_pin,
    output logic o_serial_clock_pin,
    output logic o_serial_clock_pin_oe,
    // Status
    output logic o_byte_done_irq,
    output logic o_tx_ready
);

    // ****************************************
    // Mode decode
    // ****************************************
    logic [7:0] ctrl_sw_q;
    ctrl_t sw;
    logic two_wire_on, master_on, slave_on;

    assign sw = ctrl_t'(ctrl_sw_q);
    assign two_wire_on = ~i_sync_port_control[PORT_SELECT_BIT];
    assign master_on = two_wire_on & sw.role_select;
    assign slave_on = two_wire_on & ~sw.role_select & ~sw.slave_reset;

    // ****************************************
    // Pin synchronisers and bus events
    // ****************************************
    logic sda_meta_q, sda_q, sda_prev_q;
    logic scl_meta_q, scl_q, scl_prev_q;
    logic scl_rise, scl_fall, bus_start, bus_stop, evt_ok;

    // Two flops per pin, then a history flop for edges
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sda_meta_q <= 1'b1;
            sda_q <= 1'b1;
            sda_prev_q <= 1'b1;
            scl_meta_q <= 1'b1;
            scl_q <= 1'b1;
            scl_prev_q <= 1'b1;
        end else begin
            sda_meta_q <= i_serial_data_pin;
            sda_q <= sda_meta_q;
            sda_prev_q <= sda_q;
            scl_meta_q <= i_serial_clock_pin;
            scl_q <= scl_meta_q;
            scl_prev_q <= scl_q;
        end
    end

    // Clock edges, start and stop conditions
    assign scl_rise = scl_q & ~scl_prev_q;
    assign scl_fall = ~scl_q & scl_prev_q;
    assign bus_start = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
    assign bus_stop = scl_q & scl_prev_q & ~sda_prev_q & sda_q;
    assign evt_ok = slave_on & ~bus_start & ~bus_stop;

    // ****************************************
    // SFR decode and registers
    // ****************************************
    logic data_wr, data_rd, data_access, ctrl_wr, own_wr;
    logic sw_data_in_q, direction_q, flag_q;
    logic [7:0] own_addr_q, rx_byte_q;
    ctrl_t ctrl_view;

    assign data_wr = i_sfr_wr & (i_sfr_addr == DATA_OFFSET);
    assign data_rd = i_sfr_rd & (i_sfr_addr == DATA_OFFSET);
    assign data_access = data_wr | data_rd;
    assign ctrl_wr = i_sfr_wr & (i_sfr_addr == CTRL_OFFSET);
    assign own_wr = i_sfr_wr & (i_sfr_addr == OWN_ADDR_OFFSET);

    // Software-owned control bits
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_sw_q <= CTRL_RESET & CTRL_WR_MASK;
        end else if (ctrl_wr) begin
            ctrl_sw_q <= i_sfr_wdata & CTRL_WR_MASK;
        end
    end

    // Own slave address
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            own_addr_q <= OWN_ADDR_RESET;
        end else if (own_wr) begin
            own_addr_q <= i_sfr_wdata;
        end
    end

    // Master data input latched on the clock rise
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sw_data_in_q <= 1'b0;
        end else if (master_on && scl_rise && !sw.sw_data_drive_enable) begin
            sw_data_in_q <= sda_q;
        end
    end

    // Control register as software reads it
    always_comb begin
        ctrl_view = sw;
        ctrl_view.sw_data_in = sw_data_in_q;
        ctrl_view.slave_direction = direction_q;
        ctrl_view.byte_done_flag = flag_q;
    end

    // Read data, unmapped offsets answer zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_sfr_rdata <= 8'h00;
        end else if (i_sfr_rd) begin
            case (i_sfr_addr)
                DATA_OFFSET: o_sfr_rdata <= rx_byte_q;
                OWN_ADDR_OFFSET: o_sfr_rdata <= own_addr_q;
                CTRL_OFFSET: o_sfr_rdata <= ctrl_view;
                default: o_sfr_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Transmit FIFO
    // ****************************************
    logic fifo_valid, tx_load;
    logic [BYTE_W-1:0] fifo_data;

    byte_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_valid(data_wr),
        .i_in_data(i_sfr_wdata),
        .o_in_ready(o_tx_ready),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(tx_load)
    );

    // ****************************************
    // Slave byte engine
    // ****************************************
    slave_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q, tx_sh_q;
    logic load_q, sda_low_q, byte_end, addr_match, rx_done, tx_done;

    assign byte_end = scl_fall & (bit_cnt_q == BITS_PER_BYTE);
    assign addr_match = (shift_q[7:1] == own_addr_q[6:0]);
    assign tx_load = evt_ok & (state_q == ST_TX_BYTE) & load_q & fifo_valid;
    assign rx_done = evt_ok & (state_q == ST_RX_BYTE) & byte_end;
    assign tx_done = evt_ok & (state_q == ST_TX_BYTE) & ~load_q & byte_end;

    // Sequencer, shift registers and direction
    always_ff @(posedge i_clk) begin
        if (i_rst || !slave_on) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            load_q <= 1'b0;
            sda_low_q <= 1'b0;
            if (i_rst) begin
                shift_q <= 8'h00;
                tx_sh_q <= 8'h00;
                direction_q <= 1'b0;
            end
        end else if (bus_start) begin
            state_q <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            load_q <= 1'b0;
            sda_low_q <= 1'b0;
        end else if (bus_stop) begin
            state_q <= ST_IDLE;
            load_q <= 1'b0;
            sda_low_q <= 1'b0;
        end else begin
            case (state_q)
                ST_ADDR, ST_RX_BYTE: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_q};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (byte_end && state_q == ST_RX_BYTE) begin
                        state_q <= ST_RX_ACK;
                        sda_low_q <= 1'b1;
                    end else if (byte_end && addr_match) begin
                        state_q <= ST_ADDR_ACK;
                        sda_low_q <= 1'b1;
                        direction_q <= shift_q[0];
                    end else if (byte_end) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        sda_low_q <= 1'b0;
                        bit_cnt_q <= 4'h0;
                        state_q <= direction_q ? ST_TX_BYTE : ST_RX_BYTE;
                        load_q <= direction_q;
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        sda_low_q <= 1'b0;
                        bit_cnt_q <= 4'h0;
                        state_q <= ST_RX_BYTE;
                    end
                end
                ST_TX_BYTE: begin
                    if (tx_load) begin
                        load_q <= 1'b0;
                        tx_sh_q <= fifo_data;
                        sda_low_q <= ~fifo_data[7];
                    end else if (load_q) begin
                        load_q <= 1'b1;
                    end else if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (byte_end) begin
                        state_q <= ST_TX_ACK;
                        sda_low_q <= 1'b0;
                    end else if (scl_fall) begin
                        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                        sda_low_q <= ~tx_sh_q[6];
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise && sda_q) begin
                        state_q <= ST_IDLE;
                    end else if (scl_fall) begin
                        state_q <= ST_TX_BYTE;
                        bit_cnt_q <= 4'h0;
                        load_q <= 1'b1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Last received byte
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rx_byte_q <= DATA_RESET;
        end else if (rx_done) begin
            rx_byte_q <= shift_q;
        end
    end

    // Byte done flag, a new byte wins over a clearing access
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flag_q <= 1'b0;
        end else if (rx_done || tx_done) begin
            flag_q <= 1'b1;
        end else if (data_access) begin
            flag_q <= 1'b0;
        end
    end

    assign o_byte_done_irq = flag_q;

    // ****************************************
    // Shared pin drivers
    // ****************************************
    pin_drive_t data_drv_q, clock_drv_q;

    // Pins go to SPI or to the two-wire logic, open drain in two-wire mode
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            data_drv_q <= '{o: 1'b0, oe: 1'b0};
            clock_drv_q <= '{o: 1'b0, oe: 1'b0};
        end else if (!two_wire_on) begin
            data_drv_q <= '{o: i_spi_data_o, oe: i_spi_data_oe};
            clock_drv_q <= '{o: i_spi_clock_o, oe: i_spi_clock_oe};
        end else if (sw.role_select) begin
            data_drv_q <= '{o: 1'b0, oe: sw.sw_data_drive_enable & ~sw.sw_data_out};
            clock_drv_q <= '{o: 1'b0, oe: ~sw.sw_clock_out};
        end else begin
            data_drv_q <= '{o: 1'b0, oe: sda_low_q};
            clock_drv_q <= '{o: 1'b0, oe: load_q}; // Stretch while waiting for a byte
        end
    end

    assign o_serial_data_pin = data_drv_q.o;
    assign o_serial_data_pin_oe = data_drv_q.oe;
    assign o_serial_clock_pin = clock_drv_q.o;
    assign o_serial_clock_pin_oe = clock_drv_q.oe;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence rx_byte_ends;
        rx_done ##1 1'b1;
    endsequence

    sequence addr_miss;
        evt_ok && state_q == ST_ADDR && byte_end && !addr_match;
    endsequence

    spi_owns_pins_a: assert property (
        !two_wire_on |=> o_serial_data_pin_oe == $past(i_spi_data_oe)
    ) else $error("SPI drive not on data pin");

    master_data_drive_a: assert property (
        master_on && sw.sw_data_drive_enable && !sw.sw_data_out |=> o_serial_data_pin_oe
    ) else $error("Master data low not driven");

    master_data_input_a: assert property (
        master_on && !sw.sw_data_drive_enable |=> !o_serial_data_pin_oe && !o_serial_data_pin
    ) else $error("Master data pin not released");

    master_clock_follow_a: assert property (
        master_on |=> o_serial_clock_pin_oe == !$past(sw.sw_clock_out)
    ) else $error("Clock pin does not follow clock bit");

    data_in_latch_a: assert property (
        master_on && scl_rise && !sw.sw_data_drive_enable |=> sw_data_in_q == $past(sda_q)
    ) else $error("Data input bit not latched");

    slave_reset_hold_a: assert property (
        two_wire_on && !sw.role_select && sw.slave_reset |=> state_q == ST_IDLE [*2]
    ) else $error("Slave engine not held in reset");

    tx_direction_a: assert property (
        state_q == ST_TX_BYTE |-> direction_q
    ) else $error("Transmit without direction bit");

    rx_done_flag_a: assert property (
        rx_byte_ends |-> flag_q && rx_byte_q == $past(shift_q)
    ) else $error("Received byte not flagged");

    data_clear_a: assert property (
        data_access && !rx_done && !tx_done |=> !flag_q && !o_byte_done_irq
    ) else $error("Data access did not clear flag");

    addr_reset_a: assert property (
        $fell(i_rst) |-> own_addr_q == OWN_ADDR_RESET
    ) else $error("Own address reset value wrong");

    addr_miss_idle_a: assert property (
        addr_miss |=> state_q == ST_IDLE && !sda_low_q
    ) else $error("Slave answered a foreign address");

    open_drain_a: assert property (
        two_wire_on |=> !o_serial_data_pin && !o_serial_clock_pin
    ) else $error("Two-wire pin driven high");

endmodule : two_wire_serial_port

`default_nettype wire

// File: tb/two_wire_master_model.sv
// Bus master model on the open-drain clock and data lines
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model (
    // Clock and wire levels
    input wire logic i_clk,
    input wire logic i_scl,
    input wire logic i_sda,
    // Pull-low requests
    output logic o_scl_low,
    output logic o_sda_low
);
    int hp = 6;
    // Lines are only pulled low or let go
    initial o_scl_low = 1'b0;
    initial o_sda_low = 1'b0;
    // Half a bit time
    task automatic half();
        repeat (hp) @(posedge i_clk);
    endtask : half
    // Data level to leave on the line, low means pull
    task automatic put(input logic b);
        o_sda_low <= ~b;
    endtask : put
    // Let the clock go and wait out any stretching
    task automatic up();
        o_scl_low <= 1'b0;
        @(posedge i_clk);
        for (int n = 0; n < 4000 && i_scl !== 1'b1; n++)
            @(posedge i_clk);
        half();
    endtask : up
    // One bit, sampled late in the high phase
    task automatic bit_x(input logic b, output logic r);
        put(b);
        half();
        up();
        r = i_sda;
        o_scl_low <= 1'b1;
        half();
    endtask : bit_x
    // Start when s is low, stop when s is high
    task automatic edge_x(input logic s);
        put(~s);
        half();
        up();
        put(s);
        half();
        o_scl_low <= ~s;
        half();
    endtask : edge_x
    // Eight bits first to last, then the acknowledge bit
    task automatic xfer(input logic [7:0] v, input logic ab, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--)
            bit_x(v[i], r[i]);
        bit_x(ab, a);
    endtask : xfer
endmodule : two_wire_master_model
`default_nettype wire

// File: tb/test_two_wire_serial_port.sv
// Self-checking bench: register reads scored from a queue, master model on the pins
`timescale 1ns/1ps
`default_nettype none
module test_two_wire_serial_port
    import two_wire_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_sfr_addr;
    logic [7:0] i_sfr_wdata;
    logic i_sfr_wr;
    logic i_sfr_rd;
    logic [7:0] i_sync_port_control;
    logic [3:0] spi;
    logic [7:0] o_sfr_rdata, r, dat, tx[16], q[$];
    logic o_serial_data_pin, o_serial_data_pin_oe, o_serial_clock_pin, o_serial_clock_pin_oe;
    logic o_byte_done_irq, o_tx_ready, m_scl, m_sda, a, rd_q = 1'b0;
    int errors = 0, compares = 0, cyc = 0, seed = 91;
    wire logic [7:0] pins = {4'h0, o_serial_data_pin, o_serial_data_pin_oe,
                             o_serial_clock_pin, o_serial_clock_pin_oe};
    wire logic i_serial_data_pin, i_serial_clock_pin;
    // Open-drain wires with pull-ups
    assign i_serial_data_pin = ~((o_serial_data_pin_oe & ~o_serial_data_pin) | m_sda);
    assign i_serial_clock_pin = ~((o_serial_clock_pin_oe & ~o_serial_clock_pin) | m_scl);
    // Core clock
    always #2.5 i_clk = ~i_clk;
    two_wire_serial_port #(.FIFO_DEPTH(16)) i_dut (
        .i_clk, .i_rst, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata,
        .i_sync_port_control, .i_spi_data_o(spi[3]), .i_spi_data_oe(spi[2]),
        .i_spi_clock_o(spi[1]), .i_spi_clock_oe(spi[0]), .i_serial_data_pin,
        .o_serial_data_pin, .o_serial_data_pin_oe, .i_serial_clock_pin, .o_serial_clock_pin,
        .o_serial_clock_pin_oe, .o_byte_done_irq, .o_tx_ready
    );
    two_wire_master_model i_master (
        .i_clk, .i_scl(i_serial_clock_pin), .i_sda(i_serial_data_pin),
        .o_scl_low(m_scl), .o_sda_low(m_sda)
    );
    // Compare and count
    task automatic ck(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask : ck
    // One register strobe, held up to the edge that takes it
    task automatic sfr(input logic w, input logic [7:0] ad, input logic [7:0] d);
        @(posedge i_clk);
        i_sfr_addr <= ad;
        i_sfr_wdata <= d;
        i_sfr_wr <= w;
        i_sfr_rd <= ~w;
        @(posedge i_clk);
        i_sfr_wr <= 1'b0;
        i_sfr_rd <= 1'b0;
    endtask : sfr
    // Read with its expected value noted first
    task automatic rx(input logic [7:0] ad, input logic [7:0] e);
        q.push_back(e);
        sfr(1'b0, ad, 8'h00);
    endtask : rx
    // Verdict and end of run
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // Read answers scored against the oldest note; hang guard
    always @(posedge i_clk) begin
        rd_q <= i_sfr_rd;
        if (rd_q)
            ck(o_sfr_rdata, q.pop_front());
        cyc++;
        if (cyc == 40000) begin
            errors++;
            tally_and_finish();
        end
    end
    // Main sequence
    initial begin
        // Quiet register port and SPI requests during reset
        {i_sfr_addr, i_sfr_wdata, i_sfr_wr, i_sfr_rd} <= 18'h0;
        {i_sync_port_control, spi} <= 12'h0;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        ck(pins, 8'h00);
        ck({6'h0, o_byte_done_irq, o_tx_ready}, 8'h01);
        rx(CTRL_OFFSET, CTRL_RESET);
        rx(OWN_ADDR_OFFSET, OWN_ADDR_RESET);
        rx(DATA_OFFSET, DATA_RESET);
        rx(8'h00, 8'h00);
        sfr(1'b1, OWN_ADDR_OFFSET, 8'h2a);
        rx(OWN_ADDR_OFFSET, 8'h2a);
        sfr(1'b1, CTRL_OFFSET, 8'hff);
        rx(CTRL_OFFSET, CTRL_WR_MASK);
        // Software master: every mix of data, enable and clock bits
        for (int i = 0; i < 8; i++) begin
            sfr(1'b1, CTRL_OFFSET, {i[2:0], 5'h08});
            repeat (2) @(posedge i_clk);
            ck(pins, {5'h0, i[1] & ~i[2], 1'b0, ~i[0]});
        end
        // Data line latched on a software clock rise
        for (int i = 0; i < 2; i++) begin
            i_master.put(i[0]);
            sfr(1'b1, CTRL_OFFSET, 8'h08);
            sfr(1'b1, CTRL_OFFSET, 8'h28);
            repeat (8) @(posedge i_clk);
            rx(CTRL_OFFSET, {3'h1, i[0], 4'h8});
        end
        // Pins handed to the other port
        for (int i = 0; i < 4; i++) begin
            i_sync_port_control <= 8'($random(seed)) | 8'h20;
            spi <= 4'($random(seed));
            repeat (3) @(posedge i_clk);
            ck(pins, {4'h0, spi});
        end
        i_sync_port_control <= 8'($random(seed)) & 8'hdf;
        i_master.put(1'b1);
        sfr(1'b1, CTRL_OFFSET, 8'h00);
        repeat (2) @(posedge i_clk);
        ck(pins, 8'h00);
        // Slave receives one byte
        dat = 8'($random(seed));
        i_master.edge_x(1'b0);
        i_master.xfer({7'h2a, 1'b0}, 1'b1, r, a);
        ck({7'h0, a}, 8'h00);
        i_master.xfer(dat, 1'b1, r, a);
        ck({6'h0, o_byte_done_irq, a}, 8'h02);
        i_master.edge_x(1'b1);
        // Bit 4 still holds the last master sample, a high level
        rx(CTRL_OFFSET, 8'h11);
        rx(DATA_OFFSET, dat);
        @(posedge i_clk);
        ck({7'h0, o_byte_done_irq}, 8'h00);
        // Foreign address, then own address while held in reset
        for (int k = 0; k < 2; k++) begin
            sfr(1'b1, CTRL_OFFSET, {5'h0, k[0], 2'h0});
            i_master.edge_x(1'b0);
            i_master.xfer({6'h15, ~k[0], 1'b0}, 1'b1, r, a);
            i_master.edge_x(1'b1);
            ck({7'h0, a}, 8'h01);
        end
        sfr(1'b1, CTRL_OFFSET, 8'h00);
        // Fill the transmit buffer until it refuses
        for (int i = 0; i < 16; i++) begin
            tx[i] = 8'($random(seed));
            sfr(1'b1, DATA_OFFSET, tx[i]);
        end
        @(posedge i_clk);
        ck({7'h0, o_tx_ready}, 8'h00);
        sfr(1'b1, DATA_OFFSET, 8'h00);
        // Slow master drains it
        i_master.hp = 12;
        i_master.edge_x(1'b0);
        i_master.xfer({7'h2a, 1'b1}, 1'b1, r, a);
        ck({7'h0, a}, 8'h00);
        for (int i = 0; i < 16; i++) begin
            i_master.xfer(8'hff, i == 15, r, a);
            ck(r, tx[i]);
        end
        i_master.edge_x(1'b1);
        rx(CTRL_OFFSET, 8'h13);
        ck({7'h0, o_tx_ready}, 8'h01);
        // Let the last read answer be scored
        repeat (2) @(posedge i_clk);
        tally_and_finish();
    end
endmodule : test_two_wire_serial_port
`default_nettype wire
